// ===== hdl/dma_pkg.sv
// Purpose: Shared constants and types for the two-channel cycle-steal DMA.
// Assumes: One clock, synchronous active-low reset, simple register port.
// Notes: Register offsets are word indexes on the plain register port.
package dma_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] ADDR_CTRL0 = 4'h0;
	localparam logic [3:0] ADDR_SEL0 = 4'h1;
	localparam logic [3:0] ADDR_SRC0 = 4'h2;
	localparam logic [3:0] ADDR_DST0 = 4'h3;
	localparam logic [3:0] ADDR_RLD0 = 4'h4;
	localparam logic [3:0] ADDR_CNT0 = 4'h5;
	localparam logic [3:0] ADDR_FWD0 = 4'h6;
	localparam logic [3:0] ADDR_CH_STRIDE = 4'h8;
	localparam logic [3:0] ADDR_WAIT = 4'h7;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_PENDING = 1;
	localparam int CTRL_SRC_FWD = 2;
	localparam int CTRL_DST_FWD = 3;
	localparam int CTRL_REPEAT = 4;
	localparam int SEL_FIELD_LSB = 0;
	localparam int SEL_BANK = 4;
	localparam int SEL_SWREQ = 5;
	localparam int WAIT_SFR = 0;
	localparam int WAIT_EXT_LSB = 1;

	// ****************************************
	// Reset values and coefficients
	// ****************************************
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [3:0] SOFTWARE_SOURCE = 4'h0;
	localparam logic [2:0] COEF_SFR_ONE_WAIT = 3'h2;
	localparam logic [2:0] COEF_SFR_TWO_WAIT = 3'h3;
	localparam logic [2:0] COEF_EXT_NOWAIT_RD = 3'h1;
	localparam logic [2:0] COEF_EXT_NOWAIT_WR = 3'h2;
	localparam logic [2:0] COEF_EXT_W1 = 3'h2;
	localparam logic [2:0] COEF_EXT_W2 = 3'h3;
	localparam logic [2:0] COEF_EXT_W3 = 3'h4;
	localparam logic [2:0] COEF_INTERNAL = 3'h1;

	typedef enum logic [1:0] {
		AREA_INTERNAL,
		AREA_SFR,
		AREA_EXTERNAL
	} area_t;

endpackage

// ===== hdl/dma_cycle_if.sv
// Purpose: Carries one transfer's bus-cycle request between DMA modules.
// Assumes: Same clock on both ends.
// Notes: start is one cycle; done is one cycle.
`timescale 1ns/1ns
interface dma_cycle_if;
	logic start;
	logic [19:0] srcAddr;
	logic [19:0] dstAddr;
	dma_pkg::area_t srcArea;
	dma_pkg::area_t dstArea;
	logic sfrTwoWait;
	logic [1:0] extWait;
	logic done;
	modport ctrl (output start, srcAddr, dstAddr, srcArea, dstArea,
		sfrTwoWait, extWait, input done);
	modport seq (input start, srcAddr, dstAddr, srcArea, dstArea,
		sfrTwoWait, extWait, output done);
endinterface

// ===== hdl/dma_transfer_seq.sv
// Purpose: Times one source read plus one destination write.
// Assumes: Grant is already held by the controller.
// Notes: Length is read coefficient plus write coefficient cycles.
`timescale 1ns/1ns
module dma_transfer_seq (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Transfer request
	dma_cycle_if.seq cyc
);

	// ****************************************
	// Coefficients
	// ****************************************
	function automatic logic [2:0] coef(input dma_pkg::area_t area,
		input logic sfr2, input logic [1:0] ew, input logic isWrite);
		logic [2:0] c;
		c = dma_pkg::COEF_INTERNAL;
		if (area == dma_pkg::AREA_SFR) begin
			c = sfr2 ? dma_pkg::COEF_SFR_TWO_WAIT
				: dma_pkg::COEF_SFR_ONE_WAIT;
		end else if (area == dma_pkg::AREA_EXTERNAL) begin
			unique case (ew)
				2'h0: c = isWrite ? dma_pkg::COEF_EXT_NOWAIT_WR
					: dma_pkg::COEF_EXT_NOWAIT_RD;
				2'h1: c = dma_pkg::COEF_EXT_W1;
				2'h2: c = dma_pkg::COEF_EXT_W2;
				2'h3: c = dma_pkg::COEF_EXT_W3;
			endcase
		end
		return c;
	endfunction

	logic [3:0] remain;
	logic busy;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			remain <= 4'h0;
			busy <= 1'b0;
			cyc.done <= 1'b0;
		end else begin
			cyc.done <= 1'b0;
			if (cyc.start && !busy) begin
				remain <= {1'b0, coef(cyc.srcArea, cyc.sfrTwoWait,
					cyc.extWait, 1'b0)} + {1'b0, coef(cyc.dstArea,
					cyc.sfrTwoWait, cyc.extWait, 1'b1)} - 4'h1;
				busy <= 1'b1;
			end else if (busy) begin
				if (remain == 4'h1) begin
					busy <= 1'b0;
					cyc.done <= 1'b1;
				end
				remain <= remain - 4'h1;
			end
		end
	end

endmodule // dma_transfer_seq

// ===== hdl/dma_request_enable_arbiter.sv
// Purpose: Two-channel cycle-steal DMA enable, request and priority logic.
// Assumes: Peripheral request flags are asynchronous pins; bus sampled
// Assumes: on the falling edge of a bus clock pin (busClk).
// Notes: Addresses below AREA_SFR_TOP are SFR; from AREA_EXT_BASE up, external.
`timescale 1ns/1ns

// What this block does
// - SFR transfers use coefficient 2 for one wait, 3 for two.
// - External coefficients follow wait setting; no wait reads 1, writes 2.
// - First transfer after enable loads pointer from forward source else dest.
// - First transfer after enable reloads counter from reload register.
// - Rewriting enable as 1 rearms the reload.
// - Request source is bank bit plus four-bit select field.
// - Each request sets pending, enabled or not.
// - Pending clears just before an enabled transfer starts.
// - Software write 0 clears pending; writing 1 does nothing.
// - Writing software request bit sets pending for software source.
// - Selected peripheral flag rising sets pending.
// - Requests sampled once per bus clock period; both may set together.
// - Channel zero beats channel one.
// - Bus returns to CPU after every transfer, one CPU access between.
// - Requests are not counted; they collapse into one pending flag.
// - Requests ignore interrupt masking; peripheral flags untouched.
// - Single mode stops channel on counter underflow.
// - Repeat mode reloads counter on underflow and continues.
// - Counter underflow raises the channel's interrupt pulse.
module dma_request_enable_arbiter #(
	parameter int CNT_W = 16,
	parameter logic [19:0] AREA_SFR_TOP = 20'h0_0400,
	parameter logic [19:0] AREA_EXT_BASE = 20'h4_0000
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Register port
	input wire logic [4:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	// Peripheral request flags, sixteen per bank, two banks
	input wire logic [31:0] periphFlag,
	input wire logic busClk,
	// CPU bus handshake
	output logic busRequest,
	input wire logic busGrant,
	input wire logic cpuAccessDone,
	// Transfer status
	output logic [1:0] channelActive,
	output logic [1:0] dmaIrq,
	output logic [19:0] transferSrc,
	output logic [19:0] transferDst
);

	// ****************************************
	// Channel state
	// ****************************************
	logic [1:0] channelEnable, requestPending, sourceForward;
	logic [1:0] destinationForward, repeatMode, reloadArmed;
	logic [1:0] sourceBankSelect;
	logic [3:0] sourceSelectField [2];
	logic [19:0] sourcePointer [2];
	logic [19:0] destinationPointer [2];
	logic [19:0] forwardPointer [2];
	logic [CNT_W-1:0] reloadValue [2];
	logic [CNT_W-1:0] counter [2];
	logic sfrWaitSelect;
	logic [1:0] chipSelectWait;

	// ****************************************
	// Synchronisers and request sampling
	// ****************************************
	logic [31:0] flagMeta, flagSync, flagPrev;
	logic [2:0] clkSync;
	logic [1:0] swReq, reqSeen;
	logic [1:0] selNow, selPrev;

	function automatic logic [4:0] chanBase(input int ch);
		return (ch != 0) ? {1'b0, dma_pkg::ADDR_CH_STRIDE} : 5'h00;
	endfunction

	function automatic dma_pkg::area_t areaOf(input logic [19:0] a);
		if (a >= AREA_EXT_BASE)
			return dma_pkg::AREA_EXTERNAL;
		else if (a < AREA_SFR_TOP)
			return dma_pkg::AREA_SFR;
		return dma_pkg::AREA_INTERNAL;
	endfunction

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			flagMeta <= dma_pkg::RESET_WORD;
			flagSync <= dma_pkg::RESET_WORD;
			clkSync <= 3'h0;
		end else begin
			flagMeta <= periphFlag;
			flagSync <= flagMeta;
			clkSync <= {clkSync[1:0], busClk};
		end
	end

	// A falling edge of the bus clock closes one sampling period.
	wire periodEnd = clkSync[2] & ~clkSync[1];

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			selNow[c] = flagSync[{sourceBankSelect[c],
				sourceSelectField[c]}];
			selPrev[c] = flagPrev[{sourceBankSelect[c],
				sourceSelectField[c]}];
		end
	end

	// Edges are collected between samples; repeats within a period merge.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			flagPrev <= dma_pkg::RESET_WORD;
			reqSeen <= 2'b00;
		end else begin
			flagPrev <= flagSync;
			for (int c = 0; c < 2; c++) begin
				if (periodEnd)
					reqSeen[c] <= (selNow[c] & ~selPrev[c]) | swReq[c];
				else
					reqSeen[c] <= reqSeen[c] | (selNow[c] & ~selPrev[c])
						| swReq[c];
			end
		end
	end

	// ****************************************
	// Arbitration and bus handshake
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_REQ,
		ST_XFER,
		ST_CPU_TURN
	} arb_state_t;

	arb_state_t state;
	logic activeCh;
	logic startPulse;
	logic [1:0] startClear, underflow;
	dma_cycle_if cyc ();

	wire [1:0] ready = requestPending & channelEnable;
	wire pick = ready[0] ? 1'b0 : 1'b1;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			activeCh <= 1'b0;
			busRequest <= 1'b0;
			startPulse <= 1'b0;
			startClear <= 2'b00;
		end else begin
			startPulse <= 1'b0;
			startClear <= 2'b00;
			unique case (state)
				ST_IDLE: begin
					if (|ready) begin
						busRequest <= 1'b1;
						activeCh <= pick;
						state <= ST_REQ;
					end
				end
				ST_REQ: begin
					if (busGrant) begin
						startClear[activeCh] <= 1'b1;
						startPulse <= 1'b1;
						state <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (cyc.done) begin
						busRequest <= 1'b0;
						state <= ST_CPU_TURN;
					end
				end
				ST_CPU_TURN: begin
					if (cpuAccessDone)
						state <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Pointer, counter and mode
	// ****************************************
	wire [1:0] loadNow = startClear & reloadArmed;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			for (int c = 0; c < 2; c++) begin
				forwardPointer[c] <= 20'h0_0000;
				counter[c] <= '0;
			end
			underflow <= 2'b00;
		end else begin
			underflow <= 2'b00;
			for (int c = 0; c < 2; c++) begin
				if (loadNow[c]) begin
					forwardPointer[c] <= sourceForward[c] ? sourcePointer[c]
						: destinationPointer[c];
					counter[c] <= reloadValue[c];
				end else if (cyc.done && activeCh == 1'(c)
					&& state == ST_XFER) begin
					forwardPointer[c] <= forwardPointer[c] + 20'h0_0001;
					if (counter[c] == '0) begin
						underflow[c] <= 1'b1;
						counter[c] <= repeatMode[c] ? reloadValue[c]
							: counter[c] - 1'b1;
					end else begin
						counter[c] <= counter[c] - 1'b1;
					end
				end
			end
		end
	end

	// Pointer of the active channel goes to whichever side moves forward.
	assign cyc.start = startPulse;
	assign cyc.srcAddr = sourceForward[activeCh] ?
		(reloadArmed[activeCh] ? sourcePointer[activeCh]
		: forwardPointer[activeCh]) : sourcePointer[activeCh];
	assign cyc.dstAddr = destinationForward[activeCh] ?
		(reloadArmed[activeCh] ? destinationPointer[activeCh]
		: forwardPointer[activeCh]) : destinationPointer[activeCh];
	assign cyc.srcArea = areaOf(cyc.srcAddr);
	assign cyc.dstArea = areaOf(cyc.dstAddr);
	assign cyc.sfrTwoWait = sfrWaitSelect;
	assign cyc.extWait = chipSelectWait;

	dma_transfer_seq dma_transfer_seq_i (
		.mclk(mclk),
		.rst_b(rst_b),
		.cyc(cyc)
	);

	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			channelEnable <= 2'b00;
			requestPending <= 2'b00;
			sourceForward <= 2'b00;
			destinationForward <= 2'b00;
			repeatMode <= 2'b00;
			reloadArmed <= 2'b00;
			sourceBankSelect <= 2'b00;
			swReq <= 2'b00;
			sfrWaitSelect <= 1'b0;
			chipSelectWait <= 2'h0;
			for (int c = 0; c < 2; c++) begin
				sourceSelectField[c] <= 4'h0;
				sourcePointer[c] <= 20'h0_0000;
				destinationPointer[c] <= 20'h0_0000;
				reloadValue[c] <= '0;
			end
		end else begin
			swReq <= 2'b00;
			for (int c = 0; c < 2; c++) begin
				if (loadNow[c])
					reloadArmed[c] <= 1'b0;
				if (underflow[c] && !repeatMode[c])
					channelEnable[c] <= 1'b0;
				if (startClear[c])
					requestPending[c] <= 1'b0;
				if (regWr && regAddr == chanBase(c) + dma_pkg::ADDR_CTRL0) begin
					channelEnable[c] <= regWrData[dma_pkg::CTRL_ENABLE];
					if (regWrData[dma_pkg::CTRL_ENABLE])
						reloadArmed[c] <= 1'b1;
					if (!regWrData[dma_pkg::CTRL_PENDING])
						requestPending[c] <= 1'b0;
					sourceForward[c] <= regWrData[dma_pkg::CTRL_SRC_FWD];
					destinationForward[c] <= regWrData[dma_pkg::CTRL_DST_FWD];
					repeatMode[c] <= regWrData[dma_pkg::CTRL_REPEAT];
				end
				if (regWr && regAddr == chanBase(c) + dma_pkg::ADDR_SEL0) begin
					sourceSelectField[c] <= regWrData[dma_pkg::SEL_FIELD_LSB +: 4];
					sourceBankSelect[c] <= regWrData[dma_pkg::SEL_BANK];
					swReq[c] <= regWrData[dma_pkg::SEL_SWREQ] && !regWrData[
						dma_pkg::SEL_BANK] && regWrData[3:0]
						== dma_pkg::SOFTWARE_SOURCE;
				end
				if (regWr && regAddr == chanBase(c) + dma_pkg::ADDR_SRC0)
					sourcePointer[c] <= regWrData[19:0];
				if (regWr && regAddr == chanBase(c) + dma_pkg::ADDR_DST0)
					destinationPointer[c] <= regWrData[19:0];
				if (regWr && regAddr == chanBase(c) + dma_pkg::ADDR_RLD0)
					reloadValue[c] <= regWrData[CNT_W-1:0];
				// A sampled request wins over a clear in the same cycle.
				if (periodEnd && reqSeen[c])
					requestPending[c] <= 1'b1;
			end
			if (regWr && regAddr == {1'b0, dma_pkg::ADDR_WAIT}) begin
				sfrWaitSelect <= regWrData[dma_pkg::WAIT_SFR];
				chipSelectWait <= regWrData[dma_pkg::WAIT_EXT_LSB +: 2];
			end
		end
	end

	// ****************************************
	// Register reads and outputs
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			regRdData <= dma_pkg::RESET_WORD;
			channelActive <= 2'b00;
			dmaIrq <= 2'b00;
			transferSrc <= 20'h0_0000;
			transferDst <= 20'h0_0000;
		end else begin
			channelActive <= channelEnable;
			dmaIrq <= underflow;
			if (startPulse) begin
				transferSrc <= cyc.srcAddr;
				transferDst <= cyc.dstAddr;
			end
			regRdData <= dma_pkg::RESET_WORD;
			if (regRd) begin
				for (int c = 0; c < 2; c++) begin
					if (regAddr == chanBase(c) + dma_pkg::ADDR_CTRL0)
						regRdData <= {27'h000_0000, repeatMode[c],
							destinationForward[c], sourceForward[c],
							requestPending[c], channelEnable[c]};
					if (regAddr == chanBase(c) + dma_pkg::ADDR_SEL0)
						regRdData <= {27'h000_0000, sourceBankSelect[c],
							sourceSelectField[c]};
					if (regAddr == chanBase(c) + dma_pkg::ADDR_SRC0)
						regRdData <= {12'h000, sourcePointer[c]};
					if (regAddr == chanBase(c) + dma_pkg::ADDR_DST0)
						regRdData <= {12'h000, destinationPointer[c]};
					if (regAddr == chanBase(c) + dma_pkg::ADDR_RLD0)
						regRdData <= 32'(reloadValue[c]);
					if (regAddr == chanBase(c) + dma_pkg::ADDR_CNT0)
						regRdData <= 32'(counter[c]);
					if (regAddr == chanBase(c) + dma_pkg::ADDR_FWD0)
						regRdData <= {12'h000, forwardPointer[c]};
				end
				if (regAddr == {1'b0, dma_pkg::ADDR_WAIT})
					regRdData <= {29'h0000_0000, chipSelectWait,
						sfrWaitSelect};
			end
		end
	end

endmodule // dma_request_enable_arbiter

// ===== test/dma_request_enable_arbiter_properties.sv
// Purpose: Concurrent checks on the arbiter's top ports.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every instance of the arbiter.
`timescale 1ns/1ns
module dma_arbiter_props (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Watched ports
	input wire logic regWr,
	input wire logic busRequest,
	input wire logic busGrant,
	input wire logic cpuAccessDone,
	input wire logic [1:0] channelActive,
	input wire logic [1:0] dmaIrq,
	input wire logic [19:0] transferSrc,
	input wire logic [19:0] transferDst
);
	// ****************************************
	// Helper state and properties
	// ****************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic waitCpu;
	logic [4:0] heldCnt;
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			waitCpu <= 1'b0;
		end else if ($fell(busRequest)) begin
			waitCpu <= 1'b1;
		end else if (cpuAccessDone) begin
			waitCpu <= 1'b0;
		end
	end
	// The count saturates so a stuck grant cannot wrap back into range.
	always_ff @(posedge mclk) begin
		if (!rst_b || !(busRequest && busGrant)) begin
			heldCnt <= 5'h00;
		end else if (heldCnt != 5'h1F) begin
			heldCnt <= heldCnt + 5'h01;
		end
	end
	a_req_when_enabled: assert property (
		$rose(busRequest) |-> (|channelActive) || (|$past(channelActive)))
		else $error("Bus request with no channel enabled.");
	a_req_held_grant: assert property (
		busRequest && !busGrant |=> busRequest)
		else $error("Bus request dropped before grant.");
	a_cpu_between: assert property (waitCpu |-> !busRequest)
		else $error("Bus requested before the CPU access ended.");
	a_grant_bounded: assert property (heldCnt <= 5'h0E)
		else $error("Bus held longer than one transfer.");
	a_addr_quiet: assert property (
		!busRequest && !$past(busRequest)
		|-> $stable(transferSrc) && $stable(transferDst))
		else $error("Transfer address changed with the bus idle.");
	a_irq_pulse: assert property (
		|dmaIrq |=> (dmaIrq & $past(dmaIrq)) == 2'h0)
		else $error("Interrupt pulse longer than one cycle.");
	a_irq_in_xfer: assert property (
		|dmaIrq |-> busRequest || $past(busRequest) || $past(busRequest, 2))
		else $error("Interrupt outside a transfer.");
	a_enable_by_write: assert property (
		|(channelActive & ~$past(channelActive))
		|-> $past(regWr) || $past(regWr, 2))
		else $error("Channel enabled without a register write.");
	c_grant: cover property ($rose(busGrant));
	c_irq: cover property (|dmaIrq);
	c_both: cover property (channelActive == 2'h3 && busRequest);
endmodule // dma_arbiter_props

bind dma_request_enable_arbiter dma_arbiter_props dma_arbiter_props_i (
	.mclk(mclk), .rst_b(rst_b), .regWr(regWr), .busRequest(busRequest),
	.busGrant(busGrant), .cpuAccessDone(cpuAccessDone),
	.channelActive(channelActive), .dmaIrq(dmaIrq),
	.transferSrc(transferSrc), .transferDst(transferDst));

// ===== test/cpu_bus_model.sv
// Purpose: CPU side of the shared bus and the free bus clock pin.
// Assumes: Grant is a level held while the request stands.
// Notes: slow delays the grant by three cycles.
`timescale 1ns/1ns
module cpu_bus_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Bus handshake
	input wire logic busRequest,
	input wire logic slow,
	output logic busGrant,
	output logic cpuAccessDone,
	// Bus clock pin
	output logic busClk
);
	// ****************************************
	// Bus ownership
	// ****************************************
	typedef enum logic [1:0] {CPU_RUN, CPU_LENT, CPU_ACCESS} cpu_state_t;
	cpu_state_t state;
	logic [1:0] dly;
	logic [1:0] clkDiv;
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			clkDiv <= 2'h0;
		end else begin
			clkDiv <= clkDiv + 2'h1;
		end
	end
	assign busClk = clkDiv[1];
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state <= CPU_RUN;
			busGrant <= 1'b0;
			cpuAccessDone <= 1'b0;
			dly <= 2'h0;
		end else begin
			cpuAccessDone <= 1'b0;
			case (state)
				CPU_RUN: if (busRequest) begin
					if (!slow || dly == 2'h3) begin
						busGrant <= 1'b1;
						state <= CPU_LENT;
						dly <= 2'h0;
					end else begin
						dly <= dly + 2'h1;
					end
				end
				CPU_LENT: if (!busRequest) begin
					busGrant <= 1'b0;
					state <= CPU_ACCESS;
				end
				default: begin
					dly <= dly + 2'h1;
					if (dly == 2'h2) begin
						cpuAccessDone <= 1'b1;
						dly <= 2'h0;
						state <= CPU_RUN;
					end
				end
			endcase
		end
	end
endmodule // cpu_bus_model

// ===== test/dma_request_enable_arbiter_test.sv
// Purpose: Self-checking bench for the DMA request and enable logic.
// Assumes: Register port with read data one cycle after the strobe.
// Notes: Bus outputs are sampled on the falling clock edge; read data 1 ns after the rising edge.
`timescale 1ns/1ns
module dma_request_enable_arbiter_test;
	logic mclk, rst_b, regWr, regRd, busClk, busRequest, busGrant;
	logic cpuAccessDone, slow, irqSeen;
	logic [4:0] regAddr;
	logic [31:0] regWrData, regRdData, periphFlag;
	logic [1:0] channelActive, dmaIrq;
	logic [19:0] transferSrc, transferDst;
	int n_mismatch, checks, cycles, held;
	dma_request_enable_arbiter dma_request_enable_arbiter_i (
		.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.periphFlag(periphFlag), .busClk(busClk), .busRequest(busRequest),
		.busGrant(busGrant), .cpuAccessDone(cpuAccessDone),
		.channelActive(channelActive), .dmaIrq(dmaIrq),
		.transferSrc(transferSrc), .transferDst(transferDst));
	cpu_bus_model cpu_bus_model_i (.mclk(mclk), .rst_b(rst_b),
		.busRequest(busRequest), .slow(slow), .busGrant(busGrant),
		.cpuAccessDone(cpuAccessDone), .busClk(busClk));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [4:0] ra(input int ch, input logic [3:0] off);
		ra = 5'(off) + (ch != 0 ? 5'(dma_pkg::ADDR_CH_STRIDE) : 5'h00);
	endfunction
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1;
		cmp(regRdData, exp);
	endtask
	// Waits for one whole bus loan; a hang counts as a mismatch.
	task automatic waitXfer();
		int n;
		n = 0;
		held = 0;
		irqSeen = 1'b0;
		while (busRequest !== 1'b1 && n < 300) begin
			@(negedge mclk);
			n++;
		end
		while (busRequest !== 1'b0 && n < 300) begin
			@(negedge mclk);
			irqSeen = irqSeen | (|dmaIrq);
			held++;
			n++;
		end
		repeat (2) begin
			@(negedge mclk);
			irqSeen = irqSeen | (|dmaIrq);
		end
		cmp(32'(n < 300), 32'h1);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_pending();
		wr(ra(0, dma_pkg::ADDR_SEL0), 32'h0000_0020);
		wr(ra(0, dma_pkg::ADDR_SEL0), 32'h0000_0020);
		repeat (12) @(posedge mclk);
		rd(ra(0, dma_pkg::ADDR_CTRL0), 32'h0000_0002);
		wr(ra(0, dma_pkg::ADDR_CTRL0), 32'h0000_0000);
		rd(ra(0, dma_pkg::ADDR_CTRL0), 32'h0000_0000);
		wr(ra(0, dma_pkg::ADDR_CTRL0), 32'h0000_0002);
		rd(ra(0, dma_pkg::ADDR_CTRL0), 32'h0000_0000);
		rd(5'h1F, 32'h0000_0000);
		$display("Test pending done");
	endtask
	// The loan lasts the coefficient sum plus three handshake cycles.
	task automatic t_single(input logic [31:0] ctl, input logic [31:0] wt,
		input logic [19:0] dst, input int len);
		wr(5'(dma_pkg::ADDR_WAIT), wt);
		wr(ra(0, dma_pkg::ADDR_SRC0), 32'h0000_0100);
		wr(ra(0, dma_pkg::ADDR_DST0), 32'(dst));
		wr(ra(0, dma_pkg::ADDR_RLD0), 32'h0000_0000);
		wr(ra(0, dma_pkg::ADDR_CTRL0), ctl);
		wr(ra(0, dma_pkg::ADDR_SEL0), 32'h0000_0020);
		waitXfer();
		cmp(32'(held), 32'(len + 3));
		cmp(32'(transferSrc), 32'h0000_0100);
		cmp(32'(transferDst), 32'(dst));
		cmp(32'(irqSeen), 32'h0000_0001);
		cmp(32'(channelActive), 32'h0000_0000);
		rd(ra(0, dma_pkg::ADDR_CTRL0), ctl & 32'hFFFF_FFFC);
		rd(ra(0, dma_pkg::ADDR_FWD0), (ctl[dma_pkg::CTRL_SRC_FWD] ?
			32'h0000_0100 : 32'(dst)) + 32'h0000_0001);
		rd(ra(0, dma_pkg::ADDR_CNT0), 32'h0000_FFFF);
		$display("Test single done");
	endtask
	task automatic t_priority();
		@(posedge mclk);
		slow <= 1'b1;
		wr(ra(1, dma_pkg::ADDR_SRC0), 32'h0000_0300);
		wr(ra(1, dma_pkg::ADDR_DST0), 32'h0000_0400);
		wr(ra(1, dma_pkg::ADDR_RLD0), 32'h0000_0000);
		wr(ra(0, dma_pkg::ADDR_SEL0), 32'h0000_0003);
		wr(ra(1, dma_pkg::ADDR_SEL0), 32'h0000_0015);
		wr(ra(0, dma_pkg::ADDR_CTRL0), 32'h0000_0014);
		wr(ra(1, dma_pkg::ADDR_CTRL0), 32'h0000_0014);
		wr(ra(0, dma_pkg::ADDR_CTRL0), 32'h0000_0017);
		wr(ra(1, dma_pkg::ADDR_CTRL0), 32'h0000_0017);
		@(posedge mclk);
		periphFlag <= 32'h0020_0008;
		waitXfer();
		cmp(32'(transferSrc), 32'h0000_0100);
		waitXfer();
		cmp(32'(transferSrc), 32'h0000_0300);
		cmp(32'(channelActive), 32'h0000_0003);
		rd(ra(0, dma_pkg::ADDR_CTRL0), 32'h0000_0015);
		@(posedge mclk);
		periphFlag <= 32'h0000_0000;
		wr(ra(0, dma_pkg::ADDR_CTRL0), 32'h0000_0000);
		wr(ra(1, dma_pkg::ADDR_CTRL0), 32'h0000_0000);
		$display("Test priority done");
	endtask
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ****************************************
	// Clock, timeout and main sequence
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		rst_b = 1'b0;
		regAddr = 5'h00;
		regWrData = 32'h0000_0000;
		regWr = 1'b0;
		regRd = 1'b0;
		periphFlag = 32'h0000_0000;
		slow = 1'b0;
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		wr(5'(dma_pkg::ADDR_WAIT), 32'h0000_0000);
		t_pending();
		t_single(32'h0000_0005, 32'h0000_0000, 20'h0_0200, 4);
		t_single(32'h0000_0009, 32'h0000_0001, 20'h4_0200, 5);
		t_priority();
		conclude();
	end
endmodule // dma_request_enable_arbiter_test
